// *** fpr_pkg.sv ***
// Shared constants and carrier types for the fuse memory read/program controller.
//
// Contract
// - For a read the host presents the address and asserts the selects, then data follows.
// - To program, the address is set first and then a high goes on one or both selects.
// - The fuse pulse goes to only the target output while the other outputs stay open or high.
// - After each pulse the pulse is removed, both selects go low and the output is sensed for 0.
// - Each fuse pulse lasts between 0.05 ms and 50 ms, with 0.18 ms recommended.
// - The fuse pulse duty cycle is kept at about 20 percent.
// - A bit takes at least 1 and at most 8 fuse pulses, with 4 recommended.
// - During programming every address input is driven to a defined level, never left floating.
// - On a wired-OR board the second selects are tied low and only the first-selected part programs.
package fpr_pkg;

   localparam int          FPR_ADDR_W      = 10;
   localparam int          FPR_DATA_W      = 4;
   localparam int          FPR_CLK_MHZ     = 200;
   // Fuse pulse times in units of 10 us, so that they stay integers.
   localparam int          FPR_PW_MIN_US100 = 5;     // 0.05 ms
   localparam int          FPR_PW_REC_US100 = 18;    // 0.18 ms
   localparam int          FPR_PW_MAX_US100 = 5000;  // 50 ms
   localparam int          FPR_PW_REC_CYC   = FPR_PW_REC_US100 * 10 * FPR_CLK_MHZ;
   localparam int          FPR_DUTY_PCT     = 20;
   // Off time so that pulse over period stays at the duty figure.
   localparam int          FPR_OFF_REC_CYC  = (FPR_PW_REC_CYC * (100 - FPR_DUTY_PCT))
                                              / FPR_DUTY_PCT;
   // Address access delay is 70 ns at worst, rounded up to whole cycles.
   localparam int          FPR_ACCESS_NS    = 70;
   localparam int          FPR_ACCESS_CYC   = (FPR_ACCESS_NS * FPR_CLK_MHZ + 999) / 1000;
   // Cycles after the access delay for the pin register and the two sync stages.
   localparam int          FPR_SENSE_CYC    = 3;
   localparam int          FPR_SETUP_CYC    = 2;
   localparam int          FPR_PULSE_MIN    = 1;
   localparam int          FPR_PULSE_REC    = 4;
   localparam int          FPR_PULSE_MAX    = 8;
   localparam logic [3:0]  FPR_CNT_RST      = 4'h0;

   typedef struct packed {
      logic [FPR_ADDR_W-1:0] addr;
      logic [FPR_DATA_W-1:0] data;
   } fpr_word_t;

   typedef struct packed {
      logic       ok;
      logic       fail;
      logic [3:0] pulses;
   } fpr_prog_stat_t;

endpackage : fpr_pkg

// *** fpr_timer.sv ***
// Down-counting delay timer used for setup, access, pulse and off times.
`timescale 1ns/1ps
module fpr_timer
   import fpr_pkg::*;
#(
   parameter int W = 24
) (
   input  wire logic         clk_in,    // System clock.
   input  wire logic         rst_b_in,  // Synchronised active-low reset.
   input  wire logic         load_in,   // Start a new count.
   input  wire logic [W-1:0] count_in,  // Cycles to wait.
   output logic              done_out   // High when the count has run out.
);

   logic [W-1:0] cnt_r;
   wire          at_zero = (cnt_r == '0);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= '0;
      end else if (load_in) begin
         cnt_r <= count_in;
      end else if (!at_zero) begin
         cnt_r <= cnt_r - W'(1);
      end
   end

   // Done must not depend on load, since the sequencer loads on done.
   assign done_out = at_zero;

endmodule : fpr_timer

// *** fpr_host.sv ***
// Host controller that reads and programs the 1024 x 4 fuse memory over its pins.
`timescale 1ns/1ps
module fpr_host
   import fpr_pkg::*;
#(
   parameter int PW_CYC    = FPR_PW_REC_CYC,   // Fuse pulse width in cycles.
   parameter int OFF_CYC   = FPR_OFF_REC_CYC,  // Rest between pulses in cycles.
   parameter int MAX_PULSE = FPR_PULSE_MAX     // Pulses before giving up.
) (
   input  wire logic                  clk_in,                 // 200 MHz clock.
   input  wire logic                  rst_b_in,               // Async active-low reset.
   input  wire logic                  rd_req_in,              // Read request pulse.
   input  wire logic                  pg_req_in,              // Program request pulse.
   input  wire fpr_word_t             req_in,                 // Address, and bits to clear.
   output logic                       busy_out,               // Sequence in progress.
   output logic                       done_out,               // One-cycle completion pulse.
   output fpr_word_t                  rd_out,                 // Word read and its address.
   output fpr_prog_stat_t             stat_out,               // Programming result.
   output logic [FPR_ADDR_W-1:0]      word_select_lines_out,  // Address pins.
   output logic                       select_low_first_out,   // First select, low active.
   output logic                       select_low_second_out,  // Second select, low active.
   input  wire logic [FPR_DATA_W-1:0] word_out_lines_in,      // Sensed data outputs.
   output logic [FPR_DATA_W-1:0]      fuse_pulse_out,         // Fuse pulse per output.
   output logic [FPR_DATA_W-1:0]      fuse_pulse_oe_out       // Drive enable per output.
);

   // ------------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------------
   logic                  rst_s1_r, rst_s2_r, rst_b;
   logic [FPR_DATA_W-1:0] din_s1_r, din_s2_r;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_b = rst_s2_r;

   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         din_s1_r <= 4'hF;
         din_s2_r <= 4'hF;
      end else begin
         din_s1_r <= word_out_lines_in;
         din_s2_r <= din_s1_r;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      FPR_IDLE, FPR_RD_WAIT, FPR_PG_SETUP, FPR_PG_PULSE, FPR_PG_VERIFY, FPR_PG_OFF, FPR_DONE
   } fpr_state_t;

   fpr_state_t              st_r, st_nxt;
   logic [FPR_ADDR_W-1:0]   addr_r;
   logic [FPR_DATA_W-1:0]   todo_r, bit_r, fail_r, dout_r;
   logic [3:0]              pulses_r, total_r;
   logic                    sel_r, pulse_on_r;
   logic                    tload;
   logic [23:0]             tcount;
   logic                    tdone;

   // Lowest bit still to be cleared; one output at a time.
   logic [FPR_DATA_W-1:0]   low_bit;
   assign low_bit = todo_r & (~todo_r + 4'h1);

   wire bit_is_zero = ((din_s2_r & bit_r) == 4'h0);
   wire out_of_tries = (pulses_r >= 4'(MAX_PULSE));

   fpr_timer #(.W(24)) u_timer (
      .clk_in   (clk_in),
      .rst_b_in (rst_b),
      .load_in  (tload),
      .count_in (tcount),
      .done_out (tdone)
   );

   always_comb begin
      st_nxt = st_r;
      tload  = 1'b0;
      tcount = '0;
      case (st_r)
         FPR_IDLE: begin
            if (rd_req_in) begin
               st_nxt = FPR_RD_WAIT;
               tload  = 1'b1;
               // The pins move one cycle after the request, so the pin register counts too.
               tcount = 24'(FPR_ACCESS_CYC + FPR_SENSE_CYC);
            end else if (pg_req_in) begin
               st_nxt = FPR_PG_SETUP;
               tload  = 1'b1;
               tcount = 24'(FPR_SETUP_CYC);
            end
         end
         FPR_RD_WAIT:   if (tdone) st_nxt = FPR_DONE;
         FPR_PG_SETUP: begin
            if (tdone) begin
               if (todo_r == 4'h0) begin
                  st_nxt = FPR_DONE;
               end else begin
                  st_nxt = FPR_PG_PULSE;
                  tload  = 1'b1;
                  tcount = 24'(PW_CYC);
               end
            end
         end
         FPR_PG_PULSE: begin
            if (tdone) begin
               st_nxt = FPR_PG_VERIFY;
               tload  = 1'b1;
               tcount = 24'(FPR_ACCESS_CYC + FPR_SENSE_CYC);
            end
         end
         FPR_PG_VERIFY: begin
            if (tdone) begin
               st_nxt = FPR_PG_OFF;
               tload  = 1'b1;
               tcount = 24'(OFF_CYC);
            end
         end
         FPR_PG_OFF:    if (tdone) begin
            st_nxt = FPR_PG_SETUP;
            tload  = 1'b1;
            tcount = 24'(FPR_SETUP_CYC);
         end
         FPR_DONE:      st_nxt = FPR_IDLE;
         default:       st_nxt = FPR_IDLE;
      endcase
   end

   wire verify_end = (st_r == FPR_PG_VERIFY) && tdone;

   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         st_r       <= FPR_IDLE;
         addr_r     <= '0;
         todo_r     <= 4'h0;
         bit_r      <= 4'h0;
         fail_r     <= 4'h0;
         dout_r     <= 4'hF;
         pulses_r   <= FPR_CNT_RST;
         total_r    <= FPR_CNT_RST;
         sel_r      <= 1'b1;
         pulse_on_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r == FPR_IDLE && (rd_req_in || pg_req_in)) begin
            addr_r   <= req_in.addr;
            todo_r   <= pg_req_in && !rd_req_in ? req_in.data : 4'h0;
            fail_r   <= 4'h0;
            pulses_r <= FPR_CNT_RST;
            total_r  <= FPR_CNT_RST;
         end
         if (st_r == FPR_RD_WAIT && tdone) begin
            dout_r <= din_s2_r;
         end
         // Selects: low to read and verify, high to program.
         sel_r <= (st_nxt == FPR_PG_SETUP || st_nxt == FPR_PG_PULSE) ? 1'b1 : 1'b0;
         if (st_nxt != FPR_RD_WAIT && st_nxt != FPR_PG_VERIFY && st_nxt != FPR_PG_SETUP
             && st_nxt != FPR_PG_PULSE) begin
            sel_r <= 1'b1;
         end
         if (st_r == FPR_PG_SETUP && tdone && todo_r != 4'h0) begin
            bit_r <= low_bit;
         end
         pulse_on_r <= (st_nxt == FPR_PG_PULSE);
         if (st_r == FPR_PG_PULSE && tdone) begin
            pulses_r <= pulses_r + 4'h1;
            total_r  <= total_r + 4'h1;
         end
         if (verify_end) begin
            if (bit_is_zero) begin
               todo_r   <= todo_r & ~bit_r;
               pulses_r <= FPR_CNT_RST;
            end else if (out_of_tries) begin
               todo_r   <= todo_r & ~bit_r;
               fail_r   <= fail_r | bit_r;
               pulses_r <= FPR_CNT_RST;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         busy_out              <= 1'b0;
         done_out              <= 1'b0;
         rd_out                <= '0;
         stat_out              <= '0;
         word_select_lines_out <= '0;
         select_low_first_out  <= 1'b1;
         select_low_second_out <= 1'b1;
         fuse_pulse_out        <= 4'h0;
         fuse_pulse_oe_out     <= 4'h0;
      end else begin
         busy_out              <= (st_nxt != FPR_IDLE);
         done_out              <= (st_r == FPR_DONE);
         rd_out                <= '{addr: addr_r, data: dout_r};
         stat_out              <= '{ok: (fail_r == 4'h0), fail: (fail_r != 4'h0),
                                    pulses: total_r};
         word_select_lines_out <= addr_r;
         select_low_first_out  <= sel_r;
         select_low_second_out <= sel_r;
         fuse_pulse_out        <= pulse_on_r ? bit_r : 4'h0;
         fuse_pulse_oe_out     <= pulse_on_r ? bit_r : 4'h0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   AST_ONE_OUTPUT: assert property (@(posedge clk_in) disable iff (!rst_b)
      $onehot0(fuse_pulse_oe_out))
      else $error("More than one output pulsed at once.");
   AST_PULSE_SELECT_HIGH: assert property (@(posedge clk_in) disable iff (!rst_b)
      (fuse_pulse_oe_out != 4'h0) |-> select_low_first_out)
      else $error("Fuse pulse applied while selected.");
   AST_PULSE_WIDTH: assert property (@(posedge clk_in) disable iff (!rst_b)
      $rose(pulse_on_r) |-> pulse_on_r [*2])
      else $error("Fuse pulse shorter than two cycles.");
   AST_PULSE_LIMIT: assert property (@(posedge clk_in) disable iff (!rst_b)
      pulses_r <= 4'(MAX_PULSE))
      else $error("Pulse count beyond limit.");
   AST_VERIFY_SELECTED: assert property (@(posedge clk_in) disable iff (!rst_b)
      (st_r == FPR_PG_VERIFY) |-> !sel_r)
      else $error("Verify without both selects low.");
   AST_ADDR_STABLE: assert property (@(posedge clk_in) disable iff (!rst_b)
      (st_r == FPR_PG_PULSE) |=> $stable(addr_r))
      else $error("Address moved during a pulse.");
   AST_FAIL_FLAG: assert property (@(posedge clk_in) disable iff (!rst_b)
      (verify_end && !bit_is_zero && out_of_tries) |=> ((fail_r & bit_r) != 4'h0))
      else $error("Failure not flagged.");
   AST_STOP_ON_ZERO: assert property (@(posedge clk_in) disable iff (!rst_b)
      (verify_end && bit_is_zero) |=> ((todo_r & bit_r) == 4'h0))
      else $error("Bit pulsed again after reading zero.");

endmodule : fpr_host

// *** fpr_fuse_mem.sv ***
// Behavioural 1024 x 4 fuse memory that answers the host controller's pins.
`timescale 1ns/1ps
module fpr_fuse_mem
   import fpr_pkg::*;
#(
   parameter int ACC_NS    = FPR_ACCESS_NS,                 // Address access delay in ns.
   parameter int PW_MIN_NS = 0                              // Shortest fuse pulse in ns.
) (
   input  wire logic [FPR_ADDR_W-1:0] word_select_lines_in, // Word address.
   input  wire logic                  select_low_first_in,  // First select, low active.
   input  wire logic                  select_low_second_in, // Second select, low active.
   input  wire logic [FPR_DATA_W-1:0] pulse_in,             // Fuse pulse seen on each output.
   output logic      [FPR_DATA_W-1:0] word_out_lines_out    // Data outputs.
);
   logic [FPR_DATA_W-1:0] cells [0:1023];
   logic [FPR_DATA_W-1:0] shown;
   logic [FPR_DATA_W-1:0] last_r = 4'hF;
   logic [FPR_DATA_W-1:0] prev_r = 4'h0;
   int                    hits [int];
   int                    need = 1;
   int                    errs = 0;
   realtime               t_on [4];
   realtime               t_off = 0.0;
   realtime               last_w = 0.0;
   wire                   enabled = !select_low_first_in && !select_low_second_in;

   initial foreach (cells[i]) cells[i] = 4'hF;
   // A bit only blows after the number of pulses the bench asks for.
   always @(pulse_in) begin
      int k;
      if ($countones(pulse_in) > 1 || (pulse_in != 4'h0 && enabled)) begin
         errs++;
         $display("BAD %0t fuse pulse on a selected part or on two outputs", $time);
      end
      for (int b = 0; b < 4; b++) begin
         if (!pulse_in[b] && prev_r[b]) begin
            last_w = $realtime - t_on[b];
            t_off  = $realtime;
            if (last_w < PW_MIN_NS) begin
               errs++;
               $display("BAD %0t fuse pulse too short", $time);
            end
         end
         if (pulse_in[b] && !prev_r[b]) begin
            if (t_off > 0.0 && ($realtime - t_off) * FPR_DUTY_PCT
                < last_w * (100 - FPR_DUTY_PCT)) begin
               errs++;
               $display("BAD %0t fuse pulse duty cycle too high", $time);
            end
            t_on[b] = $realtime;
            if ($isunknown(word_select_lines_in)) errs++;
            k = int'(word_select_lines_in) * 4 + b;
            hits[k]++;
            if (hits[k] >= need) cells[word_select_lines_in][b] = 1'b0;
         end
      end
      prev_r = pulse_in;
   end
   // A released output shows the opposite of its last level, never a held value.
   always @* begin
      if (enabled) shown = cells[word_select_lines_in];
      else shown = ~last_r;
   end
   always @(shown) if (enabled) last_r = shown;
   assign #(ACC_NS) word_out_lines_out = shown;
endmodule : fpr_fuse_mem

// *** test_fpr_host.sv ***
// Self-checking bench for the fuse memory host controller.
`timescale 1ns/1ps
module test_fpr_host
   import fpr_pkg::*;
;
   logic           clk_in = 1'b0;
   logic           rst_b_in = 1'b0;
   logic           rd_req = 1'b0;
   logic           pg_req = 1'b0;
   fpr_word_t      req = '0;
   fpr_word_t      rd;
   fpr_prog_stat_t stat;
   logic           busy, done, s1, s2;
   logic [9:0]     wsl, a;
   logic [3:0]     dev, pls, oe, m;
   logic [14:0]    e;
   logic [14:0]    exp_q [$];
   int             fails = 0;
   int             check_count = 0;
   int             cyc = 0;
   int             nd;

   fpr_host #(.PW_CYC(4), .OFF_CYC(4), .MAX_PULSE(FPR_PULSE_MAX)) dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .rd_req_in(rd_req), .pg_req_in(pg_req),
      .req_in(req), .busy_out(busy), .done_out(done), .rd_out(rd), .stat_out(stat),
      .word_select_lines_out(wsl), .select_low_first_out(s1), .select_low_second_out(s2),
      .word_out_lines_in((oe & pls) | (~oe & dev)), .fuse_pulse_out(pls),
      .fuse_pulse_oe_out(oe));
   fpr_fuse_mem #(.PW_MIN_NS(20)) mem (
      .word_select_lines_in(wsl), .select_low_first_in(s1), .select_low_second_in(s2),
      .pulse_in(pls & oe), .word_out_lines_out(dev));

   initial forever #2.5 clk_in = ~clk_in;

   task automatic check(input logic [13:0] seen, input logic [13:0] want);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic end_of_test();
      fails += mem.errs;
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic issue(input logic prog, input logic [9:0] ad, input logic [3:0] msk);
      int n;
      n = 0;
      while (busy !== 1'b0) @(negedge clk_in);
      @(negedge clk_in);
      rd_req = !prog;
      pg_req = prog;
      req = '{addr: ad, data: msk};
      @(negedge clk_in);
      rd_req = 1'b0;
      pg_req = 1'b0;
      while (done !== 1'b1 && n < 3000) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 3000) fails++;
   endtask : issue

   task automatic read(input logic [9:0] ad, input logic [3:0] d);
      exp_q.push_back({1'b0, ad, d});
      issue(1'b0, ad, 4'($urandom));
   endtask : read

   task automatic prog(input logic [9:0] ad, input logic [3:0] msk, input int k,
                       input logic [5:0] st);
      mem.need = k;
      exp_q.push_back({1'b1, 8'h00, st});
      issue(1'b1, ad, msk);
   endtask : prog

   // An empty queue yields a program note no completion can match.
   always @(negedge clk_in) begin
      if (done === 1'b1) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 15'h7FFF;
         if (e[14]) check({8'h00, stat}, e[13:0]);
         else check(rd, e[13:0]);
      end
   end

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(37));
      repeat (15) @(negedge clk_in);
      check({busy, done, s1, s2, oe, 6'h00}, 14'h0C00);
      check({4'h0, wsl}, 14'h0000);
      @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (3) @(negedge clk_in);
      read(10'h000, 4'hF);
      read(10'h3FF, 4'hF);
      repeat (4) read(10'($urandom), 4'hF);
      for (int i = 0; i < 6; i++) begin
         a = {i[2:0], 7'($urandom)};
         m = 4'($urandom);
         if (m == 4'h0) m = 4'h9;
         nd = 1 + int'($urandom % 3);
         prog(a, m, nd, {2'b10, 4'($countones(m) * nd)});
         read(a, ~m);
      end
      prog(10'h3C1, 4'h2, 8, 6'h28);
      prog(10'h3C2, 4'h4, 99, 6'h18);
      read(10'h3C2, 4'hF);
      exp_q.push_back({1'b0, 10'h355, 4'hF});
      fork
         issue(1'b0, 10'h355, 4'h0);
         begin
            repeat (5) @(negedge clk_in);
            rd_req = 1'b1;
            req.addr = 10'h2AA;
            @(negedge clk_in);
            rd_req = 1'b0;
         end
      join
      repeat (40) @(negedge clk_in);
      check(14'(exp_q.size()), 14'h0000);
      end_of_test();
   end
endmodule : test_fpr_host
